// ==== core/flash_host.sv ====
// Host controller that drives an asynchronous parallel NOR flash through its pins.
// What this block does
// - Reads use select and output enable low, write enable high.
// - Reads report the time-limit flag from bit 5; reset is issued only on request.
// - Identification reads raise the high-voltage flag for that one read only.
// - Host issues erase-resume to leave suspended read.
// - Host holds reset low minimum time then waits for ready.
`timescale 1ns/100ps
`default_nettype none
`include "flash_host_defs.svh"
module flash_host
  import flash_host_pkg::*;
#(
  parameter int RESET_READY_CYC = `RESET_READY_CYC,
  parameter int SUSPEND_CYC     = `SUSPEND_CYC
) (
  input  wire logic        SYS_CLK,
  input  wire logic        SYS_RST,
  input  wire logic        REQ_VALID,
  input  wire op_t         REQ_OP,
  input  wire logic [21:0] REQ_ADDR,
  input  wire logic [15:0] REQ_WDATA,
  input  wire logic        REQ_BYTE_MODE,
  input  wire logic        REQ_PROTECT,
  output var  logic        REQ_READY,
  output var  logic        RSP_VALID,
  output var  logic [15:0] RSP_RDATA,
  output var  logic        RSP_TIME_LIMIT,
  output var  logic        RSP_SECTOR_LOCKED,
  output var  logic        SUSPENDED,
  output var  logic [20:0] FLASH_ADDR,
  output var  logic        FLASH_ADDR_LOW,
  output var  logic [15:0] FLASH_DQ_OUT,
  output var  logic        FLASH_DQ_OE,
  input  wire logic [15:0] FLASH_DQ_IN,
  output var  logic        FLASH_CE_N,
  output var  logic        FLASH_OE_N,
  output var  logic        FLASH_WE_N,
  output var  logic        FLASH_RESET_N,
  output var  logic        FLASH_BYTE_N,
  output var  logic        WRITE_PROTECT_ACCEL,
  output var  logic        ID_HIGH_VOLTAGE,
  input  wire logic        READY_BUSY_N
);
  localparam int CW       = 16;
  // Reads wait out the access time plus the two synchroniser stages on the data pins.
  localparam int SYNC_CYC = 2;

  // Refuses wait counts that the cycle counter cannot hold.
  if (RESET_READY_CYC < 1 || RESET_READY_CYC >= (1 << CW)
      || SUSPEND_CYC < 1 || SUSPEND_CYC >= (1 << CW)) begin : g_bad_counts
    $error("flash_host: wait counts must fit the cycle counter");
  end

  typedef struct packed {
    host_state_t state;
    op_t         op;
    logic [CW-1:0] cnt;
    logic        page_valid;
    logic [17:0] page_tag;
    logic        suspended;
    logic        req_ready;
    logic        rsp_valid;
    logic [15:0] rsp_rdata;
    logic        rsp_tlim;
    logic        rsp_lock;
    logic [20:0] addr;
    logic        addr_low;
    logic [15:0] dq_out;
    logic        dq_oe;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic        reset_n;
    logic        byte_n;
    logic        wp;
    logic        hv;
  } host_t;

  host_t st;
  host_t next_st;
  logic [15:0] dq_sync;
  logic        ready_sync;

  // Cycles to count from a figure, never below one.
  function automatic logic [CW-1:0] cyc(input int n);
    cyc = (n < 1) ? CW'(1) : CW'(n);
  endfunction

  flash_sync2 #(.WIDTH(16)) u_dq_sync (
    .clk  (SYS_CLK),
    .rst  (SYS_RST),
    .din  (FLASH_DQ_IN),
    .dout (dq_sync)
  );
  flash_sync2 #(.WIDTH(1)) u_rb_sync (
    .clk  (SYS_CLK),
    .rst  (SYS_RST),
    .din  (READY_BUSY_N),
    .dout (ready_sync)
  );

  // Next-state logic for the pin sequencer.
  always_comb begin
    next_st = st;
    next_st.rsp_valid = 1'b0;
    unique case (st.state)
      ST_IDLE: begin
        next_st.req_ready = 1'b1;
        next_st.wp = ~REQ_PROTECT;
        if (REQ_VALID && st.req_ready) begin
          next_st.req_ready = 1'b0;
          next_st.op = REQ_OP;
          next_st.byte_n = ~REQ_BYTE_MODE;
          next_st.addr = REQ_ADDR[21:1];
          next_st.addr_low = REQ_ADDR[0];
          next_st.hv = (REQ_OP == OP_ID_READ);
          if (REQ_OP == OP_HARD_RST) begin
            // hold reset low for the minimum pulse.
            next_st.reset_n = 1'b0;
            next_st.page_valid = 1'b0;
            next_st.suspended = 1'b0;
            next_st.cnt = cyc(`RESET_PULSE_CYC);
            next_st.state = ST_RSTLOW;
          end else if (REQ_OP == OP_READ || REQ_OP == OP_ID_READ) begin
            // read strobes; page hit uses shorter time.
            next_st.ce_n = 1'b0;
            next_st.oe_n = 1'b0;
            next_st.we_n = 1'b1;
            next_st.dq_oe = 1'b0;
            if (st.page_valid && !st.ce_n && REQ_OP == OP_READ
                && st.page_tag == REQ_ADDR[21:4]) begin
              next_st.cnt = cyc(`PAGE_ACCESS_CYC + SYNC_CYC);
            end else begin
              next_st.cnt = cyc(`ADDRESS_ACCESS_CYC + SYNC_CYC);
            end
            next_st.page_tag = REQ_ADDR[21:4];
            next_st.page_valid = (REQ_OP == OP_READ);
            next_st.state = ST_ACCESS;
          end else begin
            // address set up before the strobe falls.
            next_st.ce_n = 1'b0;
            next_st.oe_n = 1'b1;
            next_st.we_n = 1'b1;
            next_st.page_valid = 1'b0;
            unique case (REQ_OP)
              OP_SOFT_RST: next_st.dq_out = `CMD_SOFT_RESET;
              OP_SUSPEND:  next_st.dq_out = `CMD_ERASE_SUSPEND;
              OP_RESUME:   next_st.dq_out = `CMD_ERASE_RESUME;
              default:     next_st.dq_out = REQ_WDATA;
            endcase
            next_st.dq_oe = 1'b1;
            next_st.state = ST_SETUP;
          end
        end
      end
      ST_SETUP: begin
        next_st.we_n = 1'b0;
        next_st.cnt = cyc(`WRITE_PULSE_CYC);
        next_st.state = ST_WPULSE;
      end
      ST_WPULSE: begin
        if (st.cnt > CW'(1)) begin
          next_st.cnt = st.cnt - CW'(1);
        end else begin
          // data held past the rising edge.
          next_st.we_n = 1'b1;
          next_st.state = ST_HOLD;
          if (st.op == OP_SUSPEND) begin
            // wait the maximum pause time before suspended reads.
            next_st.cnt = CW'(SUSPEND_CYC);
            next_st.suspended = 1'b1;
          end else begin
            next_st.cnt = CW'(1);
          end
          // resume and soft reset both leave suspended read.
          if (st.op == OP_RESUME || st.op == OP_SOFT_RST) begin
            next_st.suspended = 1'b0;
          end
        end
      end
      ST_HOLD: begin
        next_st.ce_n = 1'b1;
        next_st.dq_oe = 1'b0;
        if (st.cnt > CW'(1)) begin
          next_st.cnt = st.cnt - CW'(1);
        end else begin
          next_st.rsp_valid = 1'b1;
          next_st.state = ST_IDLE;
        end
      end
      ST_ACCESS: begin
        if (st.cnt > CW'(1)) begin
          next_st.cnt = st.cnt - CW'(1);
        end else begin
          next_st.rsp_valid = 1'b1;
          next_st.rsp_rdata = st.byte_n ? dq_sync : {8'h00, dq_sync[7:0]};
          // report the time-limit flag on bit 5.
          next_st.rsp_tlim = dq_sync[5];
          next_st.rsp_lock = (dq_sync[7:0] == `PROT_CODE_LOCKED);
          // release output enable after the sample.
          next_st.oe_n = 1'b1;
          next_st.hv = 1'b0;
          next_st.state = ST_IDLE;
        end
      end
      ST_RSTLOW: begin
        if (st.cnt > CW'(1)) begin
          next_st.cnt = st.cnt - CW'(1);
        end else begin
          next_st.reset_n = 1'b1;
          next_st.cnt = CW'(RESET_READY_CYC);
          next_st.state = ST_RSTWAIT;
        end
      end
      ST_RSTWAIT: begin
        // wait for ready or the maximum ready time.
        if (ready_sync || st.cnt <= CW'(1)) begin
          next_st.rsp_valid = 1'b1;
          next_st.state = ST_IDLE;
        end else begin
          next_st.cnt = st.cnt - CW'(1);
        end
      end
      default: begin
        next_st.state = ST_IDLE;
      end
    endcase
  end

  // Registers the whole state; bus released at reset.
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      st <= '{state: ST_IDLE, op: OP_READ, cnt: '0, page_valid: 1'b0, page_tag: '0,
              suspended: 1'b0, req_ready: 1'b0, rsp_valid: 1'b0, rsp_rdata: '0,
              rsp_tlim: 1'b0, rsp_lock: 1'b0, addr: '0, addr_low: 1'b0, dq_out: '0,
              dq_oe: 1'b0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, reset_n: 1'b1,
              byte_n: 1'b1, wp: 1'b1, hv: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign REQ_READY           = st.req_ready;
  assign RSP_VALID           = st.rsp_valid;
  assign RSP_RDATA           = st.rsp_rdata;
  assign RSP_TIME_LIMIT      = st.rsp_tlim;
  assign RSP_SECTOR_LOCKED   = st.rsp_lock;
  assign SUSPENDED           = st.suspended;
  assign FLASH_ADDR          = st.addr;
  assign FLASH_ADDR_LOW      = st.addr_low;
  assign FLASH_DQ_OUT        = st.dq_out;
  assign FLASH_DQ_OE         = st.dq_oe;
  assign FLASH_CE_N          = st.ce_n;
  assign FLASH_OE_N          = st.oe_n;
  assign FLASH_WE_N          = st.we_n;
  assign FLASH_RESET_N       = st.reset_n;
  assign FLASH_BYTE_N        = st.byte_n;
  assign WRITE_PROTECT_ACCEL = st.wp;
  // elevated A9 level as its own flag.
  assign ID_HIGH_VOLTAGE     = st.hv;
endmodule
`default_nettype wire

// ==== core/flash_host_defs.svh ====
// Timing counts and command constants for the parallel flash host controller.
`ifndef FLASH_HOST_DEFS_SVH
`define FLASH_HOST_DEFS_SVH
`define CLK_PERIOD_NS        25
`define RESET_PULSE_MIN_NS   500
`define RESET_PULSE_CYC      ((`RESET_PULSE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_READY_MAX_NS   20000
`define RESET_READY_CYC      (`RESET_READY_MAX_NS / `CLK_PERIOD_NS)
`define ADDRESS_ACCESS_NS    70
`define ADDRESS_ACCESS_CYC   ((`ADDRESS_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PAGE_ACCESS_NS       25
`define PAGE_ACCESS_CYC      ((`PAGE_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_PULSE_NS       50
`define WRITE_PULSE_CYC      ((`WRITE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SUSPEND_MAX_NS       20000
`define SUSPEND_CYC          ((`SUSPEND_MAX_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CMD_SOFT_RESET       16'h00F0
`define CMD_ERASE_SUSPEND    16'h00B0
`define CMD_ERASE_RESUME     16'h0030
`define PROT_CODE_OPEN       8'h00
`define PROT_CODE_LOCKED     8'h01
`define ID_A9_ROW            2'h2
`endif

// ==== core/flash_host_pkg.sv ====
// Types shared by the parallel flash host controller.
package flash_host_pkg;
  typedef enum logic [2:0] {
    OP_READ    = 3'b000,
    OP_WRITE   = 3'b001,
    OP_ID_READ = 3'b010,
    OP_SOFT_RST= 3'b011,
    OP_HARD_RST= 3'b100,
    OP_SUSPEND = 3'b101,
    OP_RESUME  = 3'b110
  } op_t;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SETUP  = 3'b001,
    ST_ACCESS = 3'b010,
    ST_WPULSE = 3'b011,
    ST_RSTLOW = 3'b100,
    ST_RSTWAIT= 3'b101,
    ST_HOLD   = 3'b110
  } host_state_t;
endpackage

// ==== core/flash_sync2.sv ====
// Two-flop synchroniser for pins that arrive from the flash.
`timescale 1ns/100ps
`default_nettype none
module flash_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] din,
  output var  logic [WIDTH-1:0] dout
);
  // Refuses an empty synchroniser.
  if (WIDTH < 1) begin : g_bad_width
    $error("flash_sync2: WIDTH must be at least one");
  end
  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_t;
  sync_t st;
  sync_t next_st;
  // The first stage feeds only the second stage.
  always_comb begin
    next_st.first  = din;
    next_st.second = st.first;
  end
  // Registers both stages; reset clears them.
  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign dout = st.second;
endmodule
`default_nettype wire

// ==== test/flash_host_properties.sv ====
// Port assertions for the flash host controller.
`timescale 1ns/100ps
`default_nettype none
module flash_host_properties (
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic REQ_VALID,
  input wire logic REQ_READY,
  input wire logic RSP_VALID,
  input wire logic FLASH_CE_N,
  input wire logic FLASH_OE_N,
  input wire logic FLASH_WE_N,
  input wire logic FLASH_DQ_OE,
  input wire logic FLASH_RESET_N,
  input wire logic ID_HIGH_VOLTAGE
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  logic [7:0] low_cnt;
  // Counts the cycles the reset pin has been held low.
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST || FLASH_RESET_N) begin
      low_cnt <= 8'h00;
    end else if (low_cnt != 8'hFF) begin
      low_cnt <= low_cnt + 8'h01;
    end
  end
  read_pins_a: assert property (!FLASH_OE_N |-> !FLASH_CE_N && FLASH_WE_N && !FLASH_DQ_OE)
    else $error("read pin levels wrong");
  write_pins_a: assert property (!FLASH_WE_N |-> !FLASH_CE_N && FLASH_OE_N && FLASH_DQ_OE)
    else $error("write pin levels wrong");
  write_pulse_a: assert property ($fell(FLASH_WE_N) |-> !FLASH_WE_N ##1 !FLASH_WE_N ##1 FLASH_WE_N)
    else $error("write pulse length wrong");
  data_hold_a: assert property ($rose(FLASH_WE_N) |-> FLASH_DQ_OE && !FLASH_CE_N)
    else $error("data dropped at strobe rise");
  full_access_a: assert property ($fell(FLASH_OE_N) && $past(FLASH_CE_N) |-> !RSP_VALID[*5] ##1 RSP_VALID)
    else $error("full access time wrong");
  page_access_a: assert property ($fell(FLASH_OE_N) |-> ##[3:5] RSP_VALID)
    else $error("read answer out of window");
  reset_pulse_a: assert property ($rose(FLASH_RESET_N) |-> low_cnt >= 8'h14)
    else $error("reset pulse too short");
  rsp_pulse_a: assert property (RSP_VALID |-> !REQ_READY ##1 (REQ_READY && !RSP_VALID))
    else $error("response handshake wrong");
  take_busy_a: assert property (REQ_VALID && REQ_READY |=> !REQ_READY && !RSP_VALID)
    else $error("ready held after take");
  id_no_write_a: assert property (ID_HIGH_VOLTAGE |-> FLASH_WE_N)
    else $error("write under id voltage");
  cover property ($fell(FLASH_WE_N));
  cover property ($fell(FLASH_OE_N) && $past(FLASH_CE_N));
  cover property ($rose(FLASH_RESET_N));
endmodule
bind flash_host flash_host_properties u_props (.SYS_CLK, .SYS_RST, .REQ_VALID, .REQ_READY,
  .RSP_VALID, .FLASH_CE_N, .FLASH_OE_N, .FLASH_WE_N, .FLASH_DQ_OE, .FLASH_RESET_N,
  .ID_HIGH_VOLTAGE);
`default_nettype wire

// ==== test/flash_dev_model.sv ====
// Behavioural model of the parallel flash at its pins.
`timescale 1ns/100ps
`default_nettype none
module flash_dev_model #(
  // Secure-sector indicator this model reports: factory locked, low sector guarded.
  parameter logic [7:0] SECURE_CODE = 8'h8A
) (
  input  wire logic [20:0] FLASH_ADDR,
  input  wire logic        FLASH_ADDR_LOW,
  input  wire logic [15:0] FLASH_DQ_OUT,
  input  wire logic        FLASH_DQ_OE,
  input  wire logic        FLASH_CE_N,
  input  wire logic        FLASH_OE_N,
  input  wire logic        FLASH_WE_N,
  input  wire logic        FLASH_RESET_N,
  input  wire logic        FLASH_BYTE_N,
  input  wire logic        WRITE_PROTECT_ACCEL,
  input  wire logic        ID_HIGH_VOLTAGE,
  output wire logic [15:0] FLASH_DQ_IN,
  output wire logic        READY_BUSY_N
);
  logic [15:0] arr [256];
  logic [15:0] dout;
  logic [15:0] last = 16'h0000;
  logic [7:0]  wa;
  logic        susp = 1'b0;
  logic        arm = 1'b0;
  wire         drv = !FLASH_CE_N && !FLASH_OE_N && FLASH_RESET_N;
  // Fills the array with an address-derived pattern.
  initial begin
    foreach (arr[i]) arr[i] = {~8'(i), 8'(i)};
  end
  always_comb begin
    if (ID_HIGH_VOLTAGE && FLASH_ADDR[1:0] == 2'b11) begin
      dout = {8'h00, SECURE_CODE};
    end else if (ID_HIGH_VOLTAGE) begin
      dout = {15'h0000, !WRITE_PROTECT_ACCEL};
    end else if (susp && FLASH_ADDR[20:15] == 6'h00) begin
      dout = 16'h0008;
    end else begin
      dout = arr[FLASH_ADDR[7:0]];
    end
    if (!FLASH_BYTE_N) begin
      dout = {8'hC3, FLASH_ADDR_LOW ? dout[15:8] : dout[7:0]};
    end
  end
  always @(drv or dout) begin
    if (drv) begin
      last = dout;
    end
  end
  assign #20 FLASH_DQ_IN = drv ? dout : ~last;
  assign #150 READY_BUSY_N = FLASH_RESET_N;
  always @(negedge FLASH_WE_N) begin
    wa = FLASH_ADDR[7:0];
  end
  // a program lands at the strobe rise, whatever select does afterwards.
  always @(posedge FLASH_WE_N or negedge FLASH_RESET_N) begin
    if (!FLASH_RESET_N) begin
      susp = 1'b0;
      arm = 1'b0;
    end else if (!FLASH_CE_N && FLASH_DQ_OE) begin
      case (FLASH_DQ_OUT)
        16'h00F0: begin
          susp = 1'b0;
          arm = 1'b0;
        end
        16'h00B0: susp = 1'b1;
        16'h0030: susp = 1'b0;
        16'h00A0: arm = 1'b1;
        default: begin
          if (arm) arr[wa] = FLASH_DQ_OUT;
          arm = 1'b0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== test/flash_host_tb_top.sv ====
// Self-checking bench for the flash host controller.
`timescale 1ns/100ps
`default_nettype none
module flash_host_tb_top
  import flash_host_pkg::*;
;
  logic        SYS_CLK = 1'b0;
  logic        SYS_RST = 1'b1;
  logic        REQ_VALID = 1'b0;
  op_t         REQ_OP = OP_READ;
  logic [21:0] REQ_ADDR = 22'h000000;
  logic [15:0] REQ_WDATA = 16'h0000;
  logic        REQ_BYTE_MODE = 1'b0;
  logic        REQ_PROTECT = 1'b0;
  wire  [15:0] RSP_RDATA, FLASH_DQ_OUT, FLASH_DQ_IN;
  wire  [20:0] FLASH_ADDR;
  wire         REQ_READY, RSP_VALID, RSP_TIME_LIMIT, RSP_SECTOR_LOCKED, SUSPENDED;
  wire         FLASH_ADDR_LOW, FLASH_DQ_OE, FLASH_CE_N, FLASH_OE_N, FLASH_WE_N;
  wire         FLASH_RESET_N, FLASH_BYTE_N, WRITE_PROTECT_ACCEL, ID_HIGH_VOLTAGE, READY_BUSY_N;
  int          num_errors = 0;
  int          checks_done = 0;
  int          seed = 7352;
  logic [18:0] exp_q[$];
  logic [21:0] a;
  flash_host #(.RESET_READY_CYC(40), .SUSPEND_CYC(4)) u_dut (.SYS_CLK, .SYS_RST, .REQ_VALID,
    .REQ_OP, .REQ_ADDR, .REQ_WDATA, .REQ_BYTE_MODE, .REQ_PROTECT, .REQ_READY, .RSP_VALID,
    .RSP_RDATA, .RSP_TIME_LIMIT, .RSP_SECTOR_LOCKED, .SUSPENDED, .FLASH_ADDR, .FLASH_ADDR_LOW,
    .FLASH_DQ_OUT, .FLASH_DQ_OE, .FLASH_DQ_IN, .FLASH_CE_N, .FLASH_OE_N, .FLASH_WE_N,
    .FLASH_RESET_N, .FLASH_BYTE_N, .WRITE_PROTECT_ACCEL, .ID_HIGH_VOLTAGE, .READY_BUSY_N);
  flash_dev_model u_flash (.FLASH_ADDR, .FLASH_ADDR_LOW, .FLASH_DQ_OUT, .FLASH_DQ_OE,
    .FLASH_CE_N, .FLASH_OE_N, .FLASH_WE_N, .FLASH_RESET_N, .FLASH_BYTE_N,
    .WRITE_PROTECT_ACCEL, .ID_HIGH_VOLTAGE, .FLASH_DQ_IN, .READY_BUSY_N);
  // Clock at 40 MHz.
  always #12.5 SYS_CLK = ~SYS_CLK;
  // Prints the counts and the verdict, then stops.
  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Compares one result.
  task automatic cmp(logic [17:0] got, logic [17:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Compares one status flag.
  task automatic cmp_flag(logic got, logic exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Waits for the controller to be idle, within a bound.
  task automatic wait_ready;
    int n;
    n = 0;
    while (REQ_READY !== 1'b1) begin
      @(negedge SYS_CLK);
      n++;
      if (n > 2000) begin
        num_errors++;
        test_done();
      end
    end
  endtask
  // Issues one request and notes its expected result.
  task automatic req(op_t op, logic [21:0] ad, logic [15:0] wd, logic c);
    wait_ready();
    exp_q.push_back({c, wd[7:0] == 8'h01, wd[5], wd});
    REQ_VALID = 1'b1;
    REQ_OP = op;
    REQ_ADDR = ad;
    REQ_WDATA = wd;
    @(negedge SYS_CLK);
    REQ_VALID = 1'b0;
  endtask
  function automatic logic [15:0] pat(logic [21:0] x);
    return {~x[8:1], x[8:1]};
  endfunction
  // Pairs each response with the oldest expectation.
  always @(negedge SYS_CLK) begin
    logic [18:0] e;
    if (RSP_VALID === 1'b1) begin
      e = exp_q.size() != 0 ? exp_q.pop_front() : 19'h7FFFF;
      if (e[18]) cmp({RSP_SECTOR_LOCKED, RSP_TIME_LIMIT, RSP_RDATA}, e[17:0]);
    end
  end
  // Main sequence.
  initial begin
    repeat (4) @(negedge SYS_CLK);
    SYS_RST = 1'b0;
    for (int i = 0; i < 6; i++) begin
      a = {6'h01, 7'h00, 9'($random(seed))};
      req(OP_READ, a, pat(a), 1'b1);
      req(OP_READ, a ^ 22'h000006, pat(a ^ 22'h000006), 1'b1);
    end
    REQ_BYTE_MODE = 1'b1;
    for (int i = 0; i < 4; i++) begin
      a = {6'h01, 7'h00, 9'($random(seed))};
      req(OP_READ, a, {8'h00, a[0] ? ~a[8:1] : a[8:1]}, 1'b1);
    end
    REQ_BYTE_MODE = 1'b0;
    for (int i = 0; i < 2; i++) begin
      REQ_PROTECT = i[0];
      req(OP_ID_READ, 22'h010000, {15'h0000, i[0]}, 1'b1);
    end
    REQ_PROTECT = 1'b0;
    req(OP_ID_READ, 22'h000006, 16'h008A, 1'b1);
    $display("done reads");
    a = 22'h010040;
    req(OP_WRITE, a, 16'h0055, 1'b0);
    req(OP_READ, a, pat(a), 1'b1);
    req(OP_WRITE, a, 16'h00A0, 1'b0);
    req(OP_WRITE, a, 16'h1234, 1'b0);
    req(OP_READ, a, 16'h1234, 1'b1);
    $display("done program");
    req(OP_SUSPEND, 22'h000000, 16'h0000, 1'b0);
    wait_ready();
    cmp_flag(SUSPENDED, 1'b1);
    req(OP_READ, 22'h000010, 16'h0008, 1'b1);
    req(OP_READ, 22'h010010, pat(22'h010010), 1'b1);
    req(OP_WRITE, 22'h010020, 16'h00A0, 1'b0);
    req(OP_WRITE, 22'h010020, 16'h4321, 1'b0);
    req(OP_READ, 22'h000010, 16'h0008, 1'b1);
    req(OP_READ, 22'h010020, 16'h4321, 1'b1);
    req(OP_RESUME, 22'h000000, 16'h0000, 1'b0);
    wait_ready();
    cmp_flag(SUSPENDED, 1'b0);
    req(OP_READ, 22'h000010, pat(22'h000010), 1'b1);
    $display("done suspend");
    for (int i = 0; i < 2; i++) begin
      req(OP_SUSPEND, 22'h000000, 16'h0000, 1'b0);
      req(i[0] ? OP_HARD_RST : OP_SOFT_RST, 22'h000000, 16'h0000, 1'b0);
      wait_ready();
      cmp_flag(SUSPENDED, 1'b0);
      req(OP_READ, 22'h000012, pat(22'h000012), 1'b1);
    end
    $display("done resets");
    wait_ready();
    repeat (4) @(negedge SYS_CLK);
    // A response that never came leaves a note behind.
    if (exp_q.size() != 0) begin
      num_errors++;
    end
    test_done();
  end
endmodule
`default_nettype wire
